/* usbtx_ctrl.sv */
// Host-mode transmit endpoint control/status and endpoint 0 NAK limit.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module usbtx_ctrl
    import usbtx_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  frame_start,
    input  wire logic                  ep0_nak,
    input  wire logic                  ep0_hs_other,
    input  wire logic [NUM_TX_EP-1:0]  tx_done,
    input  wire logic [NUM_TX_EP-1:0]  tx_nak,
    input  wire logic [NUM_TX_EP-1:0]  tx_hs_other,
    input  wire logic [NUM_TX_EP-1:0]  tx_stall,
    input  wire logic [NUM_TX_EP-1:0]  tx_no_hs,
    input  wire logic [NUM_TX_EP-1:0]  tx_bulk,
    input  wire logic [NUM_TX_EP-1:0]  tx_intr,
    input  wire logic [NUM_TX_EP-1:0]  tx_dbl_buf,
    input  wire logic [14:0]           tx_nak_limit,
    output logic                       ep0_halt,
    output logic      [NUM_TX_EP-1:0]  tx_send_req,
    output logic      [NUM_TX_EP-1:0]  tx_setup_token,
    output logic      [NUM_TX_EP-1:0]  tx_toggle_clear,
    output logic      [NUM_TX_EP-1:0]  tx_flush_one,
    output logic      [NUM_TX_EP-1:0]  tx_flush_all,
    output logic      [NUM_TX_EP-1:0]  tx_abort_load,
    output logic      [NUM_TX_EP-1:0]  tx_dma_stop,
    output logic      [NUM_TX_EP-1:0]  tx_irq_set
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic rst_meta;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic [NUM_TX_EP-1:0] usbtx_ep_sel(
        input logic [ADDR_W-1:0] a);
        logic [NUM_TX_EP-1:0] s;
        s = '0;
        if (a == OFS_TXCSRL_EP1) begin
            s = 3'h1;
        end else if (a == OFS_TXCSRL_EP2) begin
            s = 3'h2;
        end else if (a == OFS_TXCSRL_EP3) begin
            s = 3'h4;
        end
        return s;
    endfunction

    logic [NUM_TX_EP-1:0] wr_sel;
    logic                 wr_naklim;

    always_comb begin
        wr_sel    = reg_wr ? usbtx_ep_sel(reg_addr) : '0;
        wr_naklim = reg_wr && (reg_addr == OFS_EP0_NAKLIM);
    end

    ////////////////////////////////////////////////////////////////////////
    // Endpoint 0 NAK limit and timer.

    logic [NAKLIM_W-1:0] nak_limit_exponent;
    logic [NAKLIM_W-1:0] next_nak_limit_exponent;
    logic                ep0_expired;
    logic                next_ep0_halt;

    always_comb begin
        next_nak_limit_exponent = nak_limit_exponent;
        if (wr_naklim) begin
            next_nak_limit_exponent = reg_wdata[NAKLIM_W-1:0];
        end
        // A fresh limit write is how software releases a halted endpoint 0.
        next_ep0_halt = (ep0_halt && !wr_naklim) || ep0_expired;
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            nak_limit_exponent <= RST_EP0_NAKLIM[NAKLIM_W-1:0];
            ep0_halt           <= 1'b0;
        end else begin
            nak_limit_exponent <= next_nak_limit_exponent;
            ep0_halt           <= next_ep0_halt;
        end
    end

    usbtx_nak_timer u_ep0_timer (
        .clk         (clk),
        .rst_b       (rst_sync_b),
        .limit       (nak_limit_exponent),
        .frame_start (frame_start),
        .nak_seen    (ep0_nak),
        .hs_other    (ep0_hs_other),
        .restart     (wr_naklim),
        .expired     (ep0_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit endpoint NAK timers.

    logic [NUM_TX_EP-1:0] nak_timeout_flag_restart;
    logic [NUM_TX_EP-1:0] tx_expired;

    genvar g;
    generate
        for (g = 0; g < NUM_TX_EP; g++) begin : g_timer
            usbtx_nak_timer u_timer (
                .clk         (clk),
                .rst_b       (rst_sync_b),
                .limit       (tx_nak_limit[g*NAKLIM_W +: NAKLIM_W]),
                .frame_start (frame_start),
                .nak_seen    (tx_nak[g] && tx_bulk[g]),
                .hs_other    (tx_hs_other[g]),
                .restart     (nak_timeout_flag_restart[g]),
                .expired     (tx_expired[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Transmit control/status state.

    logic [NUM_TX_EP-1:0] nak_timeout_flag;
    logic [NUM_TX_EP-1:0] stalled;
    logic [NUM_TX_EP-1:0] setup_req;
    logic [NUM_TX_EP-1:0] error_flag;
    logic [NUM_TX_EP-1:0] tx_packet_loaded;
    logic [1:0]           pkt_cnt [NUM_TX_EP];

    logic [NUM_TX_EP-1:0] next_nak_timeout_flag;
    logic [NUM_TX_EP-1:0] next_stalled;
    logic [NUM_TX_EP-1:0] next_setup_req;
    logic [NUM_TX_EP-1:0] next_error_flag;
    logic [NUM_TX_EP-1:0] next_tx_packet_loaded;
    logic [1:0]           next_pkt_cnt [NUM_TX_EP];
    logic [NUM_TX_EP-1:0] next_send_req;
    logic [NUM_TX_EP-1:0] next_toggle_clear;
    logic [NUM_TX_EP-1:0] next_flush_one;
    logic [NUM_TX_EP-1:0] next_flush_all;
    logic [NUM_TX_EP-1:0] next_abort_load;
    logic [NUM_TX_EP-1:0] next_dma_stop;
    logic [NUM_TX_EP-1:0] next_irq_set;

    always_comb begin
        logic       w;
        logic       flush_wr;
        logic       load_wr;
        logic       err_ev;
        logic [1:0] cap;
        w        = 1'b0;
        flush_wr = 1'b0;
        load_wr  = 1'b0;
        err_ev   = 1'b0;
        cap      = PKT_SINGLE_MAX;
        for (int i = 0; i < NUM_TX_EP; i++) begin
            w        = wr_sel[i];
            flush_wr = w && reg_wdata[B_FLUSH];
            load_wr  = w && reg_wdata[B_TX_PACKET_LOADED] && !tx_packet_loaded[i];
            err_ev   = tx_no_hs[i] && (tx_bulk[i] || tx_intr[i]);
            cap      = tx_dbl_buf[i] ? PKT_DOUBLE_MAX : PKT_SINGLE_MAX;

            next_nak_timeout_flag[i] = nak_timeout_flag[i];
            next_stalled[i]          = stalled[i];
            next_setup_req[i]        = setup_req[i];
            next_error_flag[i]       = error_flag[i];
            next_tx_packet_loaded[i] = tx_packet_loaded[i];
            next_pkt_cnt[i]          = pkt_cnt[i];
            next_toggle_clear[i]     = 1'b0;
            next_flush_one[i]        = 1'b0;
            next_flush_all[i]        = 1'b0;
            next_abort_load[i]       = 1'b0;
            next_dma_stop[i]         = 1'b0;
            next_irq_set[i]          = 1'b0;
            nak_timeout_flag_restart[i]         = w && !reg_wdata[B_NAK_TIMEOUT_FLAG];

            // Software writes: flags accept only a clearing 0.
            if (w) begin
                if (!reg_wdata[B_NAK_TIMEOUT_FLAG]) begin
                    next_nak_timeout_flag[i] = 1'b0;
                end
                if (!reg_wdata[B_STALLED]) begin
                    next_stalled[i] = 1'b0;
                end
                if (!reg_wdata[B_ERROR]) begin
                    next_error_flag[i] = 1'b0;
                end
                next_setup_req[i] = reg_wdata[B_SETUP];
                if (reg_wdata[B_TOGGLE_CLEAR_STROBE]) begin
                    next_toggle_clear[i] = 1'b1;
                end
                if (reg_wdata[B_SETUP] && !setup_req[i]) begin
                    next_toggle_clear[i] = 1'b1;
                end
                if (!reg_wdata[B_TX_PACKET_LOADED]) begin
                    next_tx_packet_loaded[i] = 1'b0;
                end
            end

            if (flush_wr && reg_wdata[B_TX_PACKET_LOADED]) begin
                // The half-loaded packet never enters the count.
                next_abort_load[i]       = 1'b1;
                next_tx_packet_loaded[i] = 1'b0;
                next_irq_set[i]          = 1'b1;
            end else if (flush_wr) begin
                // Only one packet leaves per flush, even when two are held.
                next_flush_one[i]        = 1'b1;
                next_tx_packet_loaded[i] = 1'b0;
                next_irq_set[i]          = 1'b1;
                if (pkt_cnt[i] != 2'h0) begin
                    next_pkt_cnt[i] = pkt_cnt[i] - 2'h1;
                end
            end else if (load_wr && pkt_cnt[i] < cap) begin
                next_pkt_cnt[i] = pkt_cnt[i] + 2'h1;
                // A free second buffer lets software load again at once.
                next_tx_packet_loaded[i] =
                    !(tx_dbl_buf[i] && pkt_cnt[i] == 2'h0);
            end

            if (tx_done[i]) begin
                next_tx_packet_loaded[i] = 1'b0;
                next_irq_set[i]          = 1'b1;
                if (next_pkt_cnt[i] != 2'h0) begin
                    next_pkt_cnt[i] = next_pkt_cnt[i] - 2'h1;
                end
            end

            // Hardware events come last so a set wins over a clear.
            if (tx_expired[i] && tx_bulk[i]) begin
                next_nak_timeout_flag[i] = 1'b1;
            end
            if (err_ev) begin
                next_error_flag[i]       = 1'b1;
                next_tx_packet_loaded[i] = 1'b0;
                next_irq_set[i]          = 1'b1;
                next_flush_all[i]        = 1'b1;
                next_pkt_cnt[i]          = 2'h0;
            end
            if (tx_stall[i]) begin
                next_stalled[i]          = 1'b1;
                next_dma_stop[i]         = 1'b1;
                next_flush_all[i]        = 1'b1;
                next_tx_packet_loaded[i] = 1'b0;
                next_pkt_cnt[i]          = 2'h0;
            end

            // A halted endpoint sends nothing until software clears it.
            next_send_req[i] = (next_pkt_cnt[i] != 2'h0)
                && !next_nak_timeout_flag[i];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            nak_timeout_flag <= '0;
            stalled          <= '0;
            setup_req        <= '0;
            error_flag       <= '0;
            tx_packet_loaded <= '0;
            for (int i = 0; i < NUM_TX_EP; i++) begin
                pkt_cnt[i] <= 2'h0;
            end
            tx_send_req      <= '0;
            tx_setup_token   <= '0;
            tx_toggle_clear  <= '0;
            tx_flush_one     <= '0;
            tx_flush_all     <= '0;
            tx_abort_load    <= '0;
            tx_dma_stop      <= '0;
            tx_irq_set       <= '0;
        end else begin
            nak_timeout_flag <= next_nak_timeout_flag;
            stalled          <= next_stalled;
            setup_req        <= next_setup_req;
            error_flag       <= next_error_flag;
            tx_packet_loaded <= next_tx_packet_loaded;
            for (int i = 0; i < NUM_TX_EP; i++) begin
                pkt_cnt[i] <= next_pkt_cnt[i];
            end
            tx_send_req      <= next_send_req;
            tx_setup_token   <= next_setup_req;
            tx_toggle_clear  <= next_toggle_clear;
            tx_flush_one     <= next_flush_one;
            tx_flush_all     <= next_flush_all;
            tx_abort_load    <= next_abort_load;
            tx_dma_stop      <= next_dma_stop;
            tx_irq_set       <= next_irq_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [7:0] next_reg_rdata;

    always_comb begin
        logic [NUM_TX_EP-1:0] s;
        s              = usbtx_ep_sel(reg_addr);
        next_reg_rdata = 8'h00;
        if (reg_rd && reg_addr == OFS_EP0_NAKLIM) begin
            next_reg_rdata = {3'h0, nak_limit_exponent};
        end else if (reg_rd) begin
            for (int i = 0; i < NUM_TX_EP; i++) begin
                if (s[i]) begin
                    // Strobe bits read back as zero.
                    next_reg_rdata[B_NAK_TIMEOUT_FLAG]   = nak_timeout_flag[i];
                    next_reg_rdata[B_STALLED] = stalled[i];
                    next_reg_rdata[B_SETUP]   = setup_req[i];
                    next_reg_rdata[B_ERROR]   = error_flag[i];
                    next_reg_rdata[B_FIFO_HAS_PACKET]  = pkt_cnt[i] != 2'h0;
                    next_reg_rdata[B_TX_PACKET_LOADED]   = tx_packet_loaded[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule
`default_nettype wire

/* usbtx_ctrl_asserts.sv */
// Port-level checker for the host transmit endpoint control block.
`default_nettype none
module usbtx_ctrl_asserts
    import usbtx_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_rdata,
    input  wire logic                  ep0_halt,
    input  wire logic [NUM_TX_EP-1:0]  tx_done,
    input  wire logic [NUM_TX_EP-1:0]  tx_stall,
    input  wire logic [NUM_TX_EP-1:0]  tx_no_hs,
    input  wire logic [NUM_TX_EP-1:0]  tx_bulk,
    input  wire logic [NUM_TX_EP-1:0]  tx_intr,
    input  wire logic [NUM_TX_EP-1:0]  tx_setup_token,
    input  wire logic [NUM_TX_EP-1:0]  tx_toggle_clear,
    input  wire logic [NUM_TX_EP-1:0]  tx_flush_one,
    input  wire logic [NUM_TX_EP-1:0]  tx_flush_all,
    input  wire logic [NUM_TX_EP-1:0]  tx_abort_load,
    input  wire logic [NUM_TX_EP-1:0]  tx_dma_stop,
    input  wire logic [NUM_TX_EP-1:0]  tx_irq_set
);
    logic [2:0] sel;
    logic [2:0] err_ep;
    logic [4:0] lim;
    logic [4:0] next_lim;
    ////////////////////////////////////////////////////////////////////////
    // A shadow of the limit lets reads and halts be judged exactly.
    always_comb begin
        sel = {reg_addr == OFS_TXCSRL_EP3, reg_addr == OFS_TXCSRL_EP2,
               reg_addr == OFS_TXCSRL_EP1};
        err_ep = tx_no_hs & (tx_bulk | tx_intr);
        next_lim = lim;
        if (reg_wr && reg_addr == OFS_EP0_NAKLIM) begin
            next_lim = reg_wdata[4:0];
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lim <= 5'h00;
        end else begin
            lim <= next_lim;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    stall_flush_a:
        assert property (|tx_stall |=> (tx_flush_all & tx_dma_stop
            & $past(tx_stall)) == $past(tx_stall)) else $error("stall lost");
    flush_one_a:
        assert property (reg_wr && reg_wdata[B_FLUSH] && !reg_wdata[B_TX_PACKET_LOADED]
            |=> (tx_flush_one & tx_irq_set) == $past(sel))
        else $error("flush pulse wrong");
    flush_abort_a:
        assert property (reg_wr && reg_wdata[B_FLUSH] && reg_wdata[B_TX_PACKET_LOADED]
            |=> (tx_abort_load & tx_irq_set) == $past(sel))
        else $error("abort pulse wrong");
    toggle_clear_a:
        assert property (reg_wr && reg_wdata[B_TOGGLE_CLEAR_STROBE]
            |=> (tx_toggle_clear & $past(sel)) == $past(sel))
        else $error("toggle clear missing");
    setup_clear_a:
        assert property (reg_wr && reg_wdata[B_SETUP]
            && (tx_setup_token & sel) == 3'h0
            |=> (tx_toggle_clear & $past(sel)) == $past(sel))
        else $error("setup did not clear toggle");
    read_idle_a:
        assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    limit_read_a:
        assert property (reg_rd && reg_addr == OFS_EP0_NAKLIM
            |=> reg_rdata == {3'h0, $past(lim)}) else $error("limit read");
    strobe_bits_a:
        assert property (reg_rd && sel != 3'h0 |=> !reg_rdata[B_TOGGLE_CLEAR_STROBE]
            && !reg_rdata[B_FLUSH]
            && (!reg_rdata[B_TX_PACKET_LOADED] || reg_rdata[B_FIFO_HAS_PACKET]))
        else $error("status bits inconsistent");
    setup_token_a:
        assert property (reg_wr && sel != 3'h0
            |=> (tx_setup_token & $past(sel))
            == ({3{$past(reg_wdata[B_SETUP])}} & $past(sel)))
        else $error("setup token wrong");
    done_irq_a:
        assert property (|tx_done |=> (tx_irq_set & $past(tx_done))
            == $past(tx_done)) else $error("done without flag");
    no_hs_a:
        assert property (|err_ep |=> (tx_flush_all & tx_irq_set
            & $past(err_ep)) == $past(err_ep))
        else $error("error without flush");
    halt_gate_a:
        assert property ($rose(ep0_halt) |-> lim >= NAKLIM_MIN_ON
            && lim <= NAKLIM_MAX) else $error("halt with timer off");
endmodule
bind usbtx_ctrl usbtx_ctrl_asserts i_usbtx_ctrl_asserts (.*);
`default_nettype wire

/* usbtx_ctrl_bench.sv */
// Self-checking bench for the host transmit endpoint control block.
`default_nettype none
module usbtx_ctrl_bench
    import usbtx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } usbtx_row_t;
    localparam usbtx_row_t ROWS [9] = '{
        '{OFS_EP0_NAKLIM, 8'hff, 8'h1f}, '{OFS_EP0_NAKLIM, 8'h00, 8'h00},
        '{OFS_TXCSRL_EP1, 8'h01, 8'h03}, '{OFS_TXCSRL_EP1, 8'h08, 8'h00},
        '{OFS_TXCSRL_EP3, 8'h11, 8'h13}, '{OFS_TXCSRL_EP3, 8'h08, 8'h00},
        '{OFS_TXCSRL_EP3, 8'h40, 8'h00}, '{OFS_TXCSRL_EP3, 8'h24, 8'h00},
        '{10'h200, 8'h55, 8'h00}};
    localparam logic [9:0] ADDRS [4] = '{OFS_EP0_NAKLIM, OFS_TXCSRL_EP1,
        OFS_TXCSRL_EP2, OFS_TXCSRL_EP3};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic frame_start = 1'b0;
    logic [3:0] frame_cnt = 4'h0;
    logic [2:0] tx_bulk = 3'h0, tx_intr = 3'h0, tx_dbl_buf = 3'h0;
    logic [14:0] tx_nak_limit = 15'h0002;
    logic [1:0] reply = 2'h1;
    logic [3:0] gap = 4'h3;
    logic ep0_naks = 1'b0;
    logic ep0_nak, ep0_hs_other, ep0_halt;
    logic [2:0] tx_done, tx_nak, tx_hs_other, tx_stall, tx_no_hs;
    logic [2:0] tx_send_req, tx_setup_token, tx_toggle_clear, tx_flush_one;
    logic [2:0] tx_flush_all, tx_abort_load, tx_dma_stop, tx_irq_set;
    int err_total = 0;
    int comparisons = 0;
    int k;
    ////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    always @(posedge clk) begin
        frame_cnt <= frame_cnt + 4'h1;
        frame_start <= (frame_cnt == 4'hf);
    end
    usbtx_ctrl i_usbtx_ctrl (.*);
    usbtx_target_model i_usbtx_target_model (.send_req(tx_send_req), .*);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // Bounded wait so a request that never ends cannot hang the run.
    task automatic wait_idle(input int b);
        for (int n = 0; n < 300 && tx_send_req[b] !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, ROWS[i].q);
        end
        for (int m = 0; m <= 5; m++) begin
            wr(OFS_EP0_NAKLIM, 8'(m));
            @(posedge clk iff frame_start);
            ep0_naks <= 1'b1;
            for (k = 0; k < 24 && ep0_halt !== 1'b1; k++) begin
                @(posedge clk iff frame_start);
                repeat (4) @(posedge clk);
            end
            ep0_naks <= 1'b0;
            check(8'(m < 2 ? k == 24 : k > (1 << (m - 1)) &&
                k <= (1 << (m - 1)) + 3), 8'h01);
            wr(OFS_EP0_NAKLIM, 8'h00);
            check({7'h0, ep0_halt}, 8'h00);
        end
        tx_bulk <= 3'h1;
        wr(OFS_TXCSRL_EP1, 8'h01);
        wait_idle(0);
        rd(OFS_TXCSRL_EP1, 8'h83);
        repeat (40) @(posedge clk);
        wr(OFS_TXCSRL_EP1, 8'h81);
        rd(OFS_TXCSRL_EP1, 8'h83);
        check({5'h0, tx_send_req}, 8'h00);
        reply <= 2'h0;
        wr(OFS_TXCSRL_EP1, 8'h01);
        wait_idle(0);
        rd(OFS_TXCSRL_EP1, 8'h00);
        tx_bulk <= 3'h0;
        reply <= 2'h2;
        wr(OFS_TXCSRL_EP2, 8'h01);
        wait_idle(1);
        rd(OFS_TXCSRL_EP2, 8'h20);
        wr(OFS_TXCSRL_EP2, 8'h00);
        rd(OFS_TXCSRL_EP2, 8'h00);
        reply <= 2'h3;
        gap <= 4'h9;
        tx_intr <= 3'h4;
        wr(OFS_TXCSRL_EP3, 8'h01);
        wait_idle(2);
        rd(OFS_TXCSRL_EP3, 8'h04);
        wr(OFS_TXCSRL_EP3, 8'h00);
        rd(OFS_TXCSRL_EP3, 8'h00);
        reply <= 2'h1;
        tx_dbl_buf <= 3'h2;
        wr(OFS_TXCSRL_EP2, 8'h01);
        rd(OFS_TXCSRL_EP2, 8'h02);
        wr(OFS_TXCSRL_EP2, 8'h01);
        rd(OFS_TXCSRL_EP2, 8'h03);
        wr(OFS_TXCSRL_EP2, 8'h08);
        rd(OFS_TXCSRL_EP2, 8'h02);
        wr(OFS_TXCSRL_EP2, 8'h08);
        rd(OFS_TXCSRL_EP2, 8'h00);
        wr(OFS_TXCSRL_EP1, 8'h01);
        wr(OFS_TXCSRL_EP1, 8'h09);
        check({5'h0, tx_abort_load & tx_irq_set}, 8'h01);
        wr(OFS_TXCSRL_EP1, 8'h08);
        check({5'h0, tx_flush_one & tx_irq_set}, 8'h01);
        wr(OFS_TXCSRL_EP1, 8'h11);
        wr(OFS_EP0_NAKLIM, 8'h07);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
        summarize();
    end
    // Whole run needs under two thousand cycles; the limit leaves ample room.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire

/* usbtx_nak_timer.sv */
// Frame-based NAK timeout timer for one endpoint.
`default_nettype none
module usbtx_nak_timer
    import usbtx_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic [NAKLIM_W-1:0]  limit,
    input  wire logic                 frame_start,
    input  wire logic                 nak_seen,
    input  wire logic                 hs_other,
    input  wire logic                 restart,
    output logic                      expired
);
    logic [NAK_CNT_W-1:0] count;
    logic [NAK_CNT_W-1:0] next_count;
    logic                 active;
    logic                 next_active;
    logic                 next_expired;
    logic                 enabled;

    always_comb begin
        enabled      = usbtx_nak_enabled(limit);
        next_count   = count;
        next_active  = active;
        next_expired = 1'b0;
        if (hs_other || restart || !enabled) begin
            next_count  = '0;
            next_active = 1'b0;
        end else begin
            if (nak_seen) begin
                next_active = 1'b1;
            end
            // Counting stops past the threshold so the counter never wraps.
            // Expiry is one pulse at the crossing, so no stale level can
            // undo a software clear of the flag that it sets.
            if (frame_start && active
                && count <= usbtx_nak_frames(limit)) begin
                next_count   = count + 17'h00001;
                next_expired = (count == usbtx_nak_frames(limit));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count   <= '0;
            active  <= 1'b0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            active  <= next_active;
            expired <= next_expired;
        end
    end
endmodule
`default_nettype wire

/* usbtx_pkg.sv */
// Shared constants and helpers for the host transmit endpoint control block.
`default_nettype none
package usbtx_pkg;
    localparam int          NUM_TX_EP      = 3;
    localparam int          ADDR_W         = 10;
    localparam logic [9:0]  OFS_EP0_NAKLIM = 10'h10b;
    localparam logic [9:0]  OFS_TXCSRL_EP1 = 10'h112;
    localparam logic [9:0]  OFS_TXCSRL_EP2 = 10'h122;
    localparam logic [9:0]  OFS_TXCSRL_EP3 = 10'h132;
    localparam logic [7:0]  RST_EP0_NAKLIM = 8'h00;
    localparam logic [7:0]  RST_TXCSRL     = 8'h00;
    localparam int          NAKLIM_W       = 5;
    localparam int          NAK_CNT_W      = 17;
    localparam logic [4:0]  NAKLIM_MIN_ON  = 5'h02;
    localparam logic [4:0]  NAKLIM_MAX     = 5'h10;
    // Field positions of the transmit control/status low register.
    localparam int          B_NAK_TIMEOUT_FLAG        = 7;
    localparam int          B_TOGGLE_CLEAR_STROBE        = 6;
    localparam int          B_STALLED      = 5;
    localparam int          B_SETUP        = 4;
    localparam int          B_FLUSH        = 3;
    localparam int          B_ERROR        = 2;
    localparam int          B_FIFO_HAS_PACKET       = 1;
    localparam int          B_TX_PACKET_LOADED        = 0;
    localparam logic [1:0]  PKT_SINGLE_MAX = 2'h1;
    localparam logic [1:0]  PKT_DOUBLE_MAX = 2'h2;

    // Frames a NAK stream may last before a timeout, for limit value m.
    function automatic logic [16:0] usbtx_nak_frames(input logic [4:0] m);
        logic [4:0] sh;
        sh = m - 5'h01;
        return 17'h00001 << sh;
    endfunction

    // Limit values 0 and 1, and values past 16, leave the timer off.
    function automatic logic usbtx_nak_enabled(input logic [4:0] m);
        return (m >= NAKLIM_MIN_ON) && (m <= NAKLIM_MAX);
    endfunction
endpackage
`default_nettype wire

/* usbtx_target_model.sv */
// Behavioural USB function that answers the host's transmit requests.
`default_nettype none
module usbtx_target_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] send_req,
    input  wire logic [1:0] reply,
    input  wire logic [3:0] gap,
    input  wire logic       ep0_naks,
    output logic      [2:0] tx_done,
    output logic      [2:0] tx_nak,
    output logic      [2:0] tx_hs_other,
    output logic      [2:0] tx_stall,
    output logic      [2:0] tx_no_hs,
    output logic            ep0_nak,
    output logic            ep0_hs_other
);
    logic [3:0] cnt;
    logic [1:0] tries;
    logic       fire;
    logic       mute;
    // A gap of at least one cycle lets the request drop first.
    assign fire = (cnt == gap);
    assign mute = (reply == 2'h3) && (send_req != 3'h0);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            tries <= 2'h0;
            tx_done <= 3'h0;
            tx_nak <= 3'h0;
            tx_hs_other <= 3'h0;
            tx_stall <= 3'h0;
            tx_no_hs <= 3'h0;
            ep0_nak <= 1'b0;
            ep0_hs_other <= 1'b0;
        end else begin
            cnt <= fire ? 4'h0 : cnt + 4'h1;
            tx_done <= (fire && reply == 2'h0) ? send_req : 3'h0;
            tx_hs_other <= (fire && reply == 2'h0) ? send_req : 3'h0;
            tx_nak <= (fire && reply == 2'h1) ? send_req : 3'h0;
            tx_stall <= (fire && reply == 2'h2) ? send_req : 3'h0;
            tx_no_hs <= (fire && mute && tries == 2'h2) ? send_req : 3'h0;
            ep0_nak <= fire && ep0_naks;
            ep0_hs_other <= fire && !ep0_naks;
            if (fire) begin
                tries <= (mute && tries != 2'h2) ? tries + 2'h1 : 2'h0;
            end
        end
    end
endmodule
`default_nettype wire
